// [core/dspace_map.svh]
`ifndef DSPACE_MAP_SVH
`define DSPACE_MAP_SVH
// data-space map
`define BANK_LO            8'h00
`define BANK_HI            8'h3F
`define WIN_LO             8'h40
`define WIN_HI             8'h7F
`define CORE_X             8'h80
`define CORE_W             8'h83
`define RAM_LO             8'h84
`define RAM_HI             8'hBF
`define PORT_A_DIR         8'hC4
`define PORT_B_DIR         8'hC5
`define ROM_WINDOW_BASE    8'hC9
`define ART_MODE           8'hD5
`define ART_SC1            8'hD6
`define ART_SC2            8'hD7
`define BANK_SELECT        8'hE8
`define ACCUM              8'hFF
// field positions
`define WIN_OFS_W          6
`define WIN_BASE_W         6
`define BSEL_EE0           0
`define BSEL_EE1           1
`define BSEL_RAM1          3
`define BSEL_RAM2          4
`define BSEL_RESET         8'h00
`define PC_W               12
`define STACK_DEPTH        6
`define PMEM_W             13
`endif

// [core/dspace_pkg.sv]
package dspace_pkg;
   typedef enum logic [3:0] {
      tgt_none,
      tgt_bank_none,
      tgt_ee0,
      tgt_ee1,
      tgt_ram1,
      tgt_ram2,
      tgt_window,
      tgt_core,
      tgt_ram,
      tgt_port_dir,
      tgt_art,
      tgt_periph
   } target_t;
   typedef enum logic [1:0] {
      stk_idle,
      stk_push,
      stk_pop
   } stack_op_t;
endpackage

// [core/dspace_decoder.sv]
`timescale 1ns/100ps
`include "dspace_map.svh"
module dspace_decoder #(
   parameter int PC_W        = `PC_W,
   parameter int STACK_DEPTH = `STACK_DEPTH
) (
   // clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 reset,
   // core data-space access
   input  wire logic [7:0]           data_addr,
   input  wire logic [7:0]           data_wdata,
   input  wire logic                 data_rd,
   input  wire logic                 data_wr,
   output logic      [7:0]           data_rdata,
   output dspace_pkg::target_t       target,
   // program memory window port
   output logic      [`PMEM_W-1:0]   pmem_addr,
   output logic                      pmem_rd,
   input  wire logic [7:0]           pmem_rdata,
   // external readout port
   input  wire logic                 readout_protect,
   input  wire logic                 ext_rd,
   input  wire logic [`PMEM_W-1:0]   ext_addr,
   output logic      [7:0]           ext_rdata,
   // program counter and return stack
   input  wire logic [PC_W-1:0]      pc,
   input  wire logic                 stack_push,
   input  wire logic                 stack_pop,
   output logic      [PC_W-1:0]      stack_top,
   // other-target read data from the core side
   input  wire logic [7:0]           target_rdata
);

   ////////////////////////////////////////////////////////////////////////////
   // decode

   logic [7:0] bank_select_reg;
   logic [7:0] next_bank_select_reg;
   logic [5:0] rom_window_base;
   logic [5:0] next_rom_window_base;

   function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic dspace_pkg::target_t bank_target(input logic [7:0] sel);
      if (sel[`BSEL_EE0])
         bank_target = dspace_pkg::tgt_ee0;
      else if (sel[`BSEL_EE1])
         bank_target = dspace_pkg::tgt_ee1;
      else if (sel[`BSEL_RAM1])
         bank_target = dspace_pkg::tgt_ram1;
      else if (sel[`BSEL_RAM2])
         bank_target = dspace_pkg::tgt_ram2;
      else
         bank_target = dspace_pkg::tgt_bank_none;
   endfunction

   always_comb
   begin
      if (in_range(data_addr, `BANK_LO, `BANK_HI))
         target = bank_target(bank_select_reg);
      else if (in_range(data_addr, `WIN_LO, `WIN_HI))
         target = dspace_pkg::tgt_window;
      else if (in_range(data_addr, `CORE_X, `CORE_W) || data_addr == `ACCUM)
         target = dspace_pkg::tgt_core;
      else if (in_range(data_addr, `RAM_LO, `RAM_HI))
         target = dspace_pkg::tgt_ram;
      else if (data_addr == `PORT_A_DIR || data_addr == `PORT_B_DIR)
         target = dspace_pkg::tgt_port_dir;
      else if (in_range(data_addr, `ART_MODE, `ART_SC2))
         target = dspace_pkg::tgt_art;
      else if (data_addr == `ROM_WINDOW_BASE || data_addr == `BANK_SELECT)
         target = dspace_pkg::tgt_none;
      else
         target = dspace_pkg::tgt_periph;
   end

   ////////////////////////////////////////////////////////////////////////////
   // write-only registers

   always_comb
   begin
      next_rom_window_base = rom_window_base;
      next_bank_select_reg = bank_select_reg;
      if (data_wr && data_addr == `ROM_WINDOW_BASE)
         next_rom_window_base = data_wdata[`WIN_BASE_W-1:0];
      if (data_wr && data_addr == `BANK_SELECT)
         next_bank_select_reg = data_wdata;
   end

   // window base keeps whatever it held: no reset branch on purpose
   always_ff @(posedge sys_clk)
   begin
      rom_window_base <= next_rom_window_base;
   end

   // bank select is not cleared by the core either; reset here only avoids X in decode
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         bank_select_reg <= `BSEL_RESET;
      else
         bank_select_reg <= next_bank_select_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // window access and read mux

   logic [7:0] next_data_rdata;
   logic [7:0] next_ext_rdata;

   always_comb
   begin
      // a 6-bit base reaches the lower 4K only; the top address bit stays low unless ext_addr takes the port below
      pmem_addr = {1'b0, rom_window_base, data_addr[`WIN_OFS_W-1:0]};
      pmem_rd   = data_rd && (target == dspace_pkg::tgt_window);
      if (ext_rd && !readout_protect && !pmem_rd)
         pmem_addr = ext_addr;
   end

   always_comb
   begin
      next_data_rdata = data_rdata;
      next_ext_rdata  = ext_rdata;
      if (data_rd)
      begin
         if (target == dspace_pkg::tgt_window)
            next_data_rdata = pmem_rdata;
         else if (data_addr == `ROM_WINDOW_BASE || data_addr == `BANK_SELECT)
            next_data_rdata = 8'hFF;
         else
            next_data_rdata = target_rdata;
      end
      if (ext_rd)
         next_ext_rdata = (readout_protect || pmem_rd) ? 8'h00 : pmem_rdata;
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         data_rdata <= 8'h00;
         ext_rdata  <= 8'h00;
      end
      else
      begin
         data_rdata <= next_data_rdata;
         ext_rdata  <= next_ext_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // return stack

   logic [PC_W-1:0] stack_mem [STACK_DEPTH];
   logic [PC_W-1:0] next_stack_mem [STACK_DEPTH];
   dspace_pkg::stack_op_t stack_op;

   always_comb
   begin
      if (stack_push)
         stack_op = dspace_pkg::stk_push;
      else if (stack_pop)
         stack_op = dspace_pkg::stk_pop;
      else
         stack_op = dspace_pkg::stk_idle;
      next_stack_mem = stack_mem;
      // shift stack: deepest entry is lost on overflow, as in the core
      case (stack_op)
         dspace_pkg::stk_push:
         begin
            for (int i = STACK_DEPTH - 1; i > 0; i--)
               next_stack_mem[i] = stack_mem[i-1];
            next_stack_mem[0] = pc;
         end
         dspace_pkg::stk_pop:
         begin
            for (int i = 0; i < STACK_DEPTH - 1; i++)
               next_stack_mem[i] = stack_mem[i+1];
         end
         default:
            next_stack_mem = stack_mem;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < STACK_DEPTH; i++)
            stack_mem[i] <= '0;
      end
      else
      begin
         stack_mem <= next_stack_mem;
      end
   end

   assign stack_top = stack_mem[0];

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_window_addr_form: assert property (@(posedge sys_clk) disable iff (reset)
      pmem_rd |-> pmem_addr == {rom_window_base, data_addr[5:0]})
      else $error("window address not base over offset");
   a_window_decode: assert property (@(posedge sys_clk) disable iff (reset)
      (data_rd && data_addr >= 8'h40 && data_addr <= 8'h7F) |-> pmem_rd)
      else $error("window range not decoded");
   a_window_data: assert property (@(posedge sys_clk) disable iff (reset)
      pmem_rd |=> data_rdata == $past(pmem_rdata))
      else $error("window byte not returned");
   a_base_load: assert property (@(posedge sys_clk) disable iff (reset)
      (data_wr && data_addr == 8'hC9) |=> rom_window_base == $past(data_wdata[5:0]))
      else $error("window base not loaded");
   a_base_read_keep: assert property (@(posedge sys_clk) disable iff (reset)
      (data_rd && !data_wr && data_addr == 8'hC9) |=> $stable(rom_window_base))
      else $error("window base disturbed by read");
   a_bank_target: assert property (@(posedge sys_clk) disable iff (reset)
      (data_addr <= 8'h3F && bank_select_reg == 8'h10) |-> target == dspace_pkg::tgt_ram2)
      else $error("bank page 2 not selected");
   a_port_dir: assert property (@(posedge sys_clk) disable iff (reset)
      (data_addr == 8'hC4 || data_addr == 8'hC5) |-> target == dspace_pkg::tgt_port_dir)
      else $error("port direction not decoded");
   a_art_decode: assert property (@(posedge sys_clk) disable iff (reset)
      (data_addr == 8'hD6) |-> target == dspace_pkg::tgt_art)
      else $error("timer register not decoded");
   a_protect_readout: assert property (@(posedge sys_clk) disable iff (reset)
      (ext_rd && readout_protect) |=> ext_rdata == 8'h00)
      else $error("protected readout leaked");
   a_stack_push: assert property (@(posedge sys_clk) disable iff (reset)
      stack_push |=> stack_top == $past(pc))
      else $error("stack return address lost");
   a_stack_unwind: assert property (@(posedge sys_clk) disable iff (reset)
      (stack_push ##1 (stack_pop && !stack_push)) |=> stack_top == $past(stack_top, 2))
      else $error("stack head not restored by pop");
   a_ram_decode: assert property (@(posedge sys_clk) disable iff (reset)
      (data_addr >= 8'h84 && data_addr <= 8'hBF) |-> target == dspace_pkg::tgt_ram)
      else $error("general ram not decoded");

endmodule

// [verif/pmem_model.sv]
`timescale 1ns/100ps
module pmem_model (
   // program memory port
   input  wire logic [12:0] pmem_addr,
   output logic      [7:0]  pmem_rdata
);
   // every location differs from its neighbours so a wrong address shows up
   assign pmem_rdata = pmem_addr[7:0] ^ {pmem_addr[12:8], 3'h5};
endmodule

// [verif/data_space_rom_window_decoder_test.sv]
`timescale 1ns/100ps
module data_space_rom_window_decoder_test;
   logic                sys_clk, reset, data_rd, data_wr, pmem_rd, pr;
   logic                readout_protect, ext_rd, stack_push, stack_pop;
   logic [7:0]          data_addr, data_wdata, data_rdata, pmem_rdata;
   logic [7:0]          ext_rdata, target_rdata, tr, a;
   logic [12:0]         pmem_addr, ext_addr, pa;
   logic [11:0]         pc, stack_top;
   logic [11:0]         stk [6];
   logic [31:0]         seed;
   logic [5:0]          base;
   dspace_pkg::target_t target, tg;
   int                  miscompares, checks_done;
   logic [7:0]          ta [12] = '{8'h40, 8'h7F, 8'h80, 8'h84, 8'hBF, 8'hC4, 8'hC5, 8'hD5,
      8'hD7, 8'hFF, 8'hD0, 8'hE8};
   dspace_pkg::target_t te [12] = '{dspace_pkg::tgt_window, dspace_pkg::tgt_window,
      dspace_pkg::tgt_core, dspace_pkg::tgt_ram, dspace_pkg::tgt_ram, dspace_pkg::tgt_port_dir,
      dspace_pkg::tgt_port_dir, dspace_pkg::tgt_art, dspace_pkg::tgt_art, dspace_pkg::tgt_core,
      dspace_pkg::tgt_periph, dspace_pkg::tgt_none};
   dspace_pkg::target_t be [4] = '{dspace_pkg::tgt_ee0, dspace_pkg::tgt_ee1,
      dspace_pkg::tgt_ram1, dspace_pkg::tgt_ram2};
   int                  bb [4] = '{0, 1, 3, 4};
////////////////////////////////////////////////////////////////////////////////
   dspace_decoder dut (.sys_clk(sys_clk), .reset(reset), .data_addr(data_addr),
      .data_wdata(data_wdata), .data_rd(data_rd), .data_wr(data_wr), .data_rdata(data_rdata),
      .target(target), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata),
      .readout_protect(readout_protect), .ext_rd(ext_rd), .ext_addr(ext_addr),
      .ext_rdata(ext_rdata), .pc(pc), .stack_push(stack_push), .stack_pop(stack_pop),
      .stack_top(stack_top), .target_rdata(target_rdata));
   pmem_model pmem (.pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));
////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] exp_pm(input logic [12:0] ad);
      return ad[7:0] ^ {ad[12:8], 3'h5};
   endfunction
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // whole-byte writes only: the write-only registers never see bit operations
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(negedge sys_clk);
      data_addr = ad;
      data_wdata = d;
      data_wr = 1'b1;
      @(negedge sys_clk);
      data_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad);
      @(negedge sys_clk);
      data_addr = ad;
      data_rd = 1'b1;
      target_rdata = 8'(rnd());
      #1;
      pa = pmem_addr;
      pr = pmem_rd;
      tr = target_rdata;
      tg = target;
      @(negedge sys_clk);
      data_rd = 1'b0;
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      $display("[ERR] run expected finish seen timeout");
      summarize();
   end
   initial
   begin
      {data_addr, data_wdata, data_rd, data_wr, readout_protect, ext_rd} = '0;
      {ext_addr, pc, stack_push, stack_pop, target_rdata} = '0;
      seed = 32'hED54C346;
      miscompares = 0;
      checks_done = 0;
      reset = 1'b1;
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk);
      reset = 1'b0;
      check("rdata_rst", data_rdata, 16'h0000);
      check("ext_rst", ext_rdata, 16'h0000);
      check("stack_rst", stack_top, 16'h0000);
      rd(8'h10);
      check("bank_rst", tg, dspace_pkg::tgt_bank_none);
      $display("test reset done");
      for (int i = 0; i < 24; i++)
      begin
         // shadow copy updated before the register itself
         base = (i == 0) ? 6'h3F : 6'(rnd());
         a = (i == 0) ? 8'h7F : {2'b01, 6'(rnd())};
         wr(8'hC9, {2'(rnd()), base});
         rd(a);
         check("pmem_addr", pa, {base, a[5:0]});
         check("pmem_rd", pr, 16'h0001);
         check("win_data", data_rdata, exp_pm({base, a[5:0]}));
      end
      rd(8'hC9);
      check("base_read", data_rdata, 16'h00FF);
      rd(a);
      check("base_kept", data_rdata, exp_pm({base, a[5:0]}));
      // the window base must ride through a reset untouched
      @(negedge sys_clk);
      reset = 1'b1;
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      check("rdata_rst2", data_rdata, 16'h0000);
      rd(a);
      check("base_rst_kept", data_rdata, exp_pm({base, a[5:0]}));
      $display("test window done");
      for (int k = 0; k < 12; k++)
      begin
         rd(ta[k]);
         check("target", tg, te[k]);
         if (k == 11)
            check("bank_sel_read", data_rdata, 16'h00FF);
         else if (k > 1)
            check("other_rd", data_rdata, tr);
      end
      for (int k = 0; k < 4; k++)
      begin
         wr(8'hE8, 8'h01 << bb[k]);
         rd({2'b00, 6'(rnd())});
         check("bank", tg, be[k]);
      end
      $display("test decode done");
      for (int i = 0; i < 8; i++)
      begin
         @(negedge sys_clk);
         readout_protect = (i < 2) ? i[0] : 1'(rnd());
         ext_addr = 13'(rnd());
         ext_rd = 1'b1;
         @(negedge sys_clk);
         ext_rd = 1'b0;
         check("ext", ext_rdata, readout_protect ? 8'h00 : exp_pm(ext_addr));
      end
      $display("test readout done");
      for (int i = 0; i < 6; i++)
      begin
         @(negedge sys_clk);
         pc = 12'(rnd());
         stk[i] = pc;
         stack_push = 1'b1;
         @(negedge sys_clk);
         stack_push = 1'b0;
         check("push", stack_top, stk[i]);
      end
      for (int i = 4; i >= 0; i--)
      begin
         @(negedge sys_clk);
         stack_pop = 1'b1;
         @(negedge sys_clk);
         stack_pop = 1'b0;
         check("pop", stack_top, stk[i]);
      end
      // push straight into pop must hand back the head held before the push
      @(negedge sys_clk);
      pc = 12'(rnd());
      stack_push = 1'b1;
      @(negedge sys_clk);
      stack_push = 1'b0;
      stack_pop = 1'b1;
      @(negedge sys_clk);
      stack_pop = 1'b0;
      check("push_pop", stack_top, stk[0]);
      $display("test stack done");
      summarize();
   end
endmodule
